// ==== src/tag_pkg.sv ====
// Shared constants and types of the tag start-up and access-state block.
// Assumes a single 20 MHz system clock; all times below are in microseconds.
package tag_pkg;
  localparam int CLK_MHZ = 20;
  localparam int BOOT_NORMAL_US = 3500;
  localparam int BOOT_RECOVER_US = 5300;
  localparam int BOOT_WRCOUNT_US = 24000;
  // Longest times: exact multiples, rounding down is a no-op here
  localparam int BOOT_NORMAL_CYC = BOOT_NORMAL_US * CLK_MHZ;
  localparam int BOOT_RECOVER_CYC = BOOT_RECOVER_US * CLK_MHZ;
  localparam int BOOT_WRCOUNT_CYC = BOOT_WRCOUNT_US * CLK_MHZ;
  localparam int BOOT_CNT_W = 20;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] BLK_SCRATCH_LAST = 8'h5e;
  localparam logic [7:0] BLK_CHALLENGE = 8'h80;
  localparam logic [7:0] BLK_DEV_MAC = 8'h81;
  localparam logic [7:0] BLK_ID = 8'h82;
  localparam logic [7:0] BLK_WRCOUNT = 8'h90;
  localparam logic [7:0] BLK_EXT_MAC = 8'h91;
  localparam logic [7:0] BLK_STATE = 8'h92;
  localparam logic [7:0] AUTH_DONE = 8'h01;
  localparam logic [7:0] WRCOUNT_RESET_REQ = 8'h00;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_MASK = 8'h0c;
  localparam logic [7:0] A_MEM_CFG = 8'h10;
  localparam logic [7:0] A_ATTR = 8'h14;
  localparam logic [7:0] A_WRLOCK = 8'h18;
  localparam logic [7:0] A_KEY_A = 8'h1c;
  localparam logic [7:0] A_KEY_B = 8'h20;
  localparam logic [7:0] A_ID_LO = 8'h24;
  localparam logic [7:0] A_ID_HI = 8'h28;
  localparam logic [7:0] A_POLL = 8'h2c;
  localparam logic [7:0] A_WRCOUNT = 8'h30;
  localparam int CTRL_MAC_BIT = 0;
  localparam int CFG_WRCOUNT_LSB = 16;
  localparam int ATTR_RO_WIRED = 0;
  localparam int ATTR_RO_RF = 1;
  localparam int ATTR_RD_AUTH = 2;
  localparam int ATTR_WR_AUTH = 3;
  localparam int ATTR_WR_MAC = 4;
  localparam int WRLOCK_WIRED_BIT = 0;
  localparam int WRLOCK_RF_BIT = 8;
  localparam int IRQ_W = 6;
  localparam logic [31:0] MEM_CFG_RESET = 32'h00ff_0000;
  localparam logic [31:0] ZERO_RESET = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] block;
    logic [31:0] data;
  } cmd_t;
  typedef struct packed {
    logic valid;
    logic ok;
    logic [31:0] data;
  } rsp_t;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_BOOT = 2'b01,
    ST_READY = 2'b10
  } boot_state_t;
endpackage

// ==== src/tag_startup_ctrl.sv ====
// Start-up, boot gating and per-interface access state of a tag memory.
// Assumes a comparator drives core_supply_ok and all inputs are synchronous.
//
// Contract
// - Request pin low closes the supply switch; high opens it, standby.
// - Core reset released at supply threshold, then boot runs.
// - Wired and wireless interfaces usable only after boot completes.
// - Supply below threshold asserts core reset; recovery releases it.
// - Carrier-detect output high while a carrier is present.
// - Ready within normal limit, or longer limit after interrupted write.
// - Config byte 2 equal to 00h resets write counter; boot within 24 ms.
// - Power lost during start-up restarts it, redoing counter reset.
// - Clock source chosen automatically: carrier clock or oscillator.
// - Separate authentication status per interface; wired needs its own.
// - Separate challenge store and session key per interface, same block.
// - Wired status byte 1 of state block set to 01h on authentication.
// - With MAC writes, write-lock refuses wired, wireless or both.
// - Carrier loss after wired start-up clears wireless state, wired lock byte, id, poll; code clears only if a wireless command came during that carrier.
// - Blocks support read-only per interface, auth and MAC attributes.
// - Mutual authentication by MAC computed over challenge data.
`timescale 1ns/100ps
module tag_startup_ctrl #(
  parameter int unsigned BOOT_NORMAL_CYCLES = tag_pkg::BOOT_NORMAL_CYC,
  parameter int unsigned BOOT_RECOVER_CYCLES = tag_pkg::BOOT_RECOVER_CYC,
  parameter int unsigned BOOT_WRCOUNT_CYCLES = tag_pkg::BOOT_WRCOUNT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic power_off_request_n,
  input wire logic core_supply_ok,
  input wire logic carrier_present,
  input wire logic interrupted_write,
  input wire tag_pkg::cmd_t cmd_wired,
  input wire tag_pkg::cmd_t cmd_rf,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output tag_pkg::rsp_t rsp_wired,
  output tag_pkg::rsp_t rsp_rf,
  output logic supply_switch_on,
  output logic standby,
  output logic core_reset,
  output logic boot_done,
  output logic carrier_detect_out,
  output logic clock_from_carrier,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  import tag_pkg::*;

  if (BOOT_NORMAL_CYCLES == 0 || BOOT_NORMAL_CYCLES > BOOT_RECOVER_CYCLES ||
      BOOT_RECOVER_CYCLES > BOOT_WRCOUNT_CYCLES || BOOT_WRCOUNT_CYCLES >= 2**BOOT_CNT_W)
  begin : g_chk
    $error("Boot cycle parameters out of range");
  end

  boot_state_t state, next_state;
  logic [BOOT_CNT_W-1:0] boot_cnt, boot_limit;
  logic wrcount_boot;
  logic [31:0] ctrl, irq_mask, mem_cfg, attr, write_lock_block, key_a, key_b;
  logic [31:0] id_lo, id_hi, poll_resp;
  logic [23:0] write_counter;
  logic [IRQ_W-1:0] irq_stat, irq_ev;
  logic wired_powered, rf_used, clear_rf;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic ap, rd_clear;
  logic [31:0] rd_mux;
  cmd_t cmd_in [2];
  rsp_t rsp_q [2];
  logic auth [2];
  logic chal_written [2];
  logic [31:0] challenge [2];
  logic [31:0] session [2];
  logic wrote [2];
  logic auth_set [2];
  logic refused [2];

  assign cmd_in[0] = cmd_wired;
  assign cmd_in[1] = cmd_rf;
  assign rsp_wired = rsp_q[0];
  assign rsp_rf = rsp_q[1];

  // Device side proof and expected reader proof over one challenge
  function automatic logic [31:0] dev_mac(input logic [31:0] s, input logic [31:0] k);
    dev_mac = s ^ k;
  endfunction

  function automatic logic [31:0] ext_mac(input logic [31:0] s, input logic [31:0] k);
    ext_mac = s ^ {k[15:0], k[31:16]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Supply switch and boot sequencing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      supply_switch_on <= 1'b0;
      standby <= 1'b1;
    end else begin
      supply_switch_on <= !power_off_request_n;
      standby <= power_off_request_n;
    end
  end

  always_comb begin
    next_state = state;
    if (power_off_request_n || !core_supply_ok) begin
      next_state = ST_OFF;
    end else begin
      case (state)
        ST_OFF: next_state = ST_BOOT;
        ST_BOOT: if (boot_cnt == boot_limit) next_state = ST_READY;
        ST_READY: next_state = ST_READY;
        default: next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
      core_reset <= 1'b1;
      boot_done <= 1'b0;
    end else begin
      state <= next_state;
      core_reset <= next_state == ST_OFF;
      boot_done <= next_state == ST_READY;
    end
  end

  // Limit is picked fresh each start, so an aborted counter reset is redone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      boot_cnt <= '0;
      boot_limit <= '0;
      wrcount_boot <= 1'b0;
    end else if (state != ST_BOOT) begin
      boot_cnt <= '0;
      if (mem_cfg[CFG_WRCOUNT_LSB +: 8] == WRCOUNT_RESET_REQ) begin
        boot_limit <= BOOT_CNT_W'(BOOT_WRCOUNT_CYCLES - 1);
        wrcount_boot <= 1'b1;
      end else if (interrupted_write) begin
        boot_limit <= BOOT_CNT_W'(BOOT_RECOVER_CYCLES - 1);
        wrcount_boot <= 1'b0;
      end else begin
        boot_limit <= BOOT_CNT_W'(BOOT_NORMAL_CYCLES - 1);
        wrcount_boot <= 1'b0;
      end
    end else begin
      boot_cnt <= boot_cnt + 1'b1;
    end
  end

  a_boot_limit_max: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state == ST_BOOT |-> boot_cnt < BOOT_CNT_W'(BOOT_WRCOUNT_CYCLES))
    else $error("Boot ran past its longest limit");
  a_boot_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(core_reset) |-> state == ST_BOOT ##1 !boot_done)
    else $error("Reset release did not start boot");
  a_supply_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !core_supply_ok |=> core_reset && !boot_done)
    else $error("Low supply did not assert core reset");
  a_switch_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    power_off_request_n |=> !supply_switch_on && standby)
    else $error("Supply switch not opened on request");

  ////////////////////////////////////////////////////////////////////////
  // Carrier, clock source, carrier-loss clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      carrier_detect_out <= 1'b0;
      clock_from_carrier <= 1'b0;
    end else begin
      carrier_detect_out <= carrier_present;
      clock_from_carrier <= carrier_present;
    end
  end

  // Only a start-up powered from the wired side arms the wireless clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wired_powered <= 1'b0;
      rf_used <= 1'b0;
    end else if (core_reset) begin
      wired_powered <= 1'b0;
      rf_used <= 1'b0;
    end else begin
      if (state == ST_BOOT && next_state == ST_READY) wired_powered <= !carrier_present;
      if (clear_rf) rf_used <= 1'b0;
      else if (cmd_in[1].valid && boot_done && carrier_detect_out) rf_used <= 1'b1;
    end
  end

  assign clear_rf = wired_powered && rf_used && carrier_detect_out && !carrier_present;

  a_carrier_out: assert property (@(posedge clk_sys) disable iff (!reset_n)
    carrier_present |=> carrier_detect_out && clock_from_carrier)
    else $error("Carrier detect output not raised");

  ////////////////////////////////////////////////////////////////////////
  // Per-interface command handling
  for (genvar i = 0; i < 2; i++) begin : g_if
    logic acc, is_scratch, ro, locked, ok, set_a, put_chal, wr_ok;
    logic [31:0] rdata;

    // Wireless commands also need a live carrier
    assign acc = cmd_in[i].valid && boot_done && (i == 0 || carrier_detect_out);
    assign is_scratch = cmd_in[i].block <= BLK_SCRATCH_LAST;
    assign ro = attr[i == 0 ? ATTR_RO_WIRED : ATTR_RO_RF];
    assign locked = ctrl[CTRL_MAC_BIT] &&
                    write_lock_block[i == 0 ? WRLOCK_WIRED_BIT : WRLOCK_RF_BIT];
    assign wr_ok = !ro && !locked && !(attr[ATTR_WR_AUTH] && !auth[i]) &&
                   !(attr[ATTR_WR_MAC] && !(ctrl[CTRL_MAC_BIT] && auth[i]));

    always_comb begin
      ok = 1'b0;
      set_a = 1'b0;
      put_chal = 1'b0;
      rdata = '0;
      if (cmd_in[i].write) begin
        if (is_scratch) begin
          ok = wr_ok;
        end else if (cmd_in[i].block == BLK_CHALLENGE) begin
          ok = !locked;
          put_chal = !locked;
        end else if (cmd_in[i].block == BLK_EXT_MAC) begin
          // Reader proves key knowledge over this side's own challenge
          ok = chal_written[i] && cmd_in[i].data == ext_mac(session[i], key_b);
          set_a = ok;
        end
      end else begin
        case (cmd_in[i].block)
          BLK_CHALLENGE: begin
            ok = 1'b1;
            rdata = challenge[i];
          end
          BLK_DEV_MAC: begin
            ok = chal_written[i];
            rdata = dev_mac(session[i], key_b);
          end
          BLK_ID: begin
            ok = 1'b1;
            rdata = id_lo;
          end
          BLK_WRCOUNT: begin
            ok = 1'b1;
            rdata = {8'h00, write_counter};
          end
          BLK_STATE: begin
            ok = 1'b1;
            rdata = {16'h0000, auth[0] ? AUTH_DONE : 8'h00,
                     auth[1] ? AUTH_DONE : 8'h00};
          end
          default: begin
            ok = is_scratch && !(attr[ATTR_RD_AUTH] && !auth[i]);
          end
        endcase
      end
    end

    assign wrote[i] = acc && cmd_in[i].write && is_scratch && ok;
    assign auth_set[i] = acc && set_a;
    assign refused[i] = acc && !ok;

    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        auth[i] <= 1'b0;
        chal_written[i] <= 1'b0;
        challenge[i] <= '0;
        session[i] <= '0;
      end else if (core_reset || (i == 1 && clear_rf)) begin
        auth[i] <= 1'b0;
        chal_written[i] <= 1'b0;
        challenge[i] <= '0;
        session[i] <= '0;
      end else if (acc && put_chal) begin
        challenge[i] <= cmd_in[i].data;
        session[i] <= cmd_in[i].data ^ key_a;
        chal_written[i] <= 1'b1;
        auth[i] <= 1'b0;
      end else if (acc && set_a) begin
        auth[i] <= 1'b1;
      end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        rsp_q[i] <= '0;
      end else begin
        rsp_q[i].valid <= acc;
        rsp_q[i].ok <= acc && ok;
        rsp_q[i].data <= (acc && ok) ? rdata : 32'h0000_0000;
      end
    end

    a_lock_refuse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      acc && cmd_in[i].write && is_scratch && locked |=> rsp_q[i].valid && !rsp_q[i].ok)
      else $error("Locked write was accepted");
  end

  a_boot_gates: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !boot_done |=> !rsp_wired.valid && !rsp_rf.valid)
    else $error("Command answered before boot finished");
  a_wired_auth: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(auth[0]) |-> $past(auth_set[0]))
    else $error("Wired authentication set without wired proof");
  a_carrier_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clear_rf |=> !auth[1] && !chal_written[1] && poll_resp == 32'h0 && id_lo == 32'h0 &&
                 !write_lock_block[WRLOCK_WIRED_BIT])
    else $error("Carrier loss did not clear wireless state");

  ////////////////////////////////////////////////////////////////////////
  // Write counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_counter <= '0;
    end else if (wrcount_boot && state == ST_BOOT && next_state == ST_READY) begin
      write_counter <= '0;
    end else begin
      write_counter <= write_counter + 24'(wrote[0]) + 24'(wrote[1]);
    end
  end

  a_wrcount_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(boot_done) && wrcount_boot |-> write_counter == 24'h0)
    else $error("Write counter not reset on start-up");

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, read data registered at the end of the address phase
  assign ap = hsel && htrans[1] && hready;
  assign rd_clear = ap && !hwrite && haddr[7:0] == A_IRQ_STAT;

  always_comb begin
    case (haddr[7:0])
      A_CTRL: rd_mux = ctrl;
      A_STATUS: rd_mux = {24'h0, carrier_detect_out, auth[1], auth[0], wired_powered,
                          boot_done, core_reset, 2'(state)};
      A_IRQ_STAT: rd_mux = {{(32-IRQ_W){1'b0}}, irq_stat};
      A_IRQ_MASK: rd_mux = irq_mask;
      A_MEM_CFG: rd_mux = mem_cfg;
      A_ATTR: rd_mux = attr;
      A_WRLOCK: rd_mux = write_lock_block;
      A_KEY_A: rd_mux = 32'h0000_0000;
      A_KEY_B: rd_mux = 32'h0000_0000;
      A_ID_LO: rd_mux = id_lo;
      A_ID_HI: rd_mux = id_hi;
      A_POLL: rd_mux = poll_resp;
      A_WRCOUNT: rd_mux = {8'h00, write_counter};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ap && hwrite;
      if (ap) wr_addr <= haddr[7:0];
      if (ap && !hwrite) hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Key registers are write-only so the card key never leaves the block
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= ZERO_RESET;
      irq_mask <= ZERO_RESET;
      mem_cfg <= MEM_CFG_RESET;
      attr <= ZERO_RESET;
      key_a <= ZERO_RESET;
      key_b <= ZERO_RESET;
      id_hi <= ZERO_RESET;
    end else if (wr_pend) begin
      case (wr_addr)
        A_CTRL: ctrl <= hwdata;
        A_IRQ_MASK: irq_mask <= hwdata;
        A_MEM_CFG: mem_cfg <= hwdata;
        A_ATTR: attr <= hwdata;
        A_KEY_A: key_a <= hwdata;
        A_KEY_B: key_b <= hwdata;
        A_ID_HI: id_hi <= hwdata;
        default: ;
      endcase
    end
  end

  // Carrier-loss clear beats a software write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_lock_block <= ZERO_RESET;
      id_lo <= ZERO_RESET;
      poll_resp <= ZERO_RESET;
    end else if (clear_rf) begin
      write_lock_block[7:0] <= 8'h00;
      id_lo <= ZERO_RESET;
      poll_resp <= ZERO_RESET;
    end else if (wr_pend) begin
      if (wr_addr == A_WRLOCK) write_lock_block <= hwdata;
      if (wr_addr == A_ID_LO) id_lo <= hwdata;
      if (wr_addr == A_POLL) poll_resp <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, read clears, a new event wins over the clear
  assign irq_ev = {refused[0] || refused[1], wrcount_boot && state == ST_BOOT &&
                   next_state == ST_READY, auth_set[1], auth_set[0], clear_rf,
                   state == ST_BOOT && next_state == ST_READY};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (rd_clear ? '0 : irq_stat) | irq_ev;
      irq <= |(irq_stat & irq_mask[IRQ_W-1:0]);
    end
  end
endmodule

// ==== test/tag_cmd_host.sv ====
// Command host for one side of the tag: wired controller or wireless reader.
// Assumes a registered answer within three cycles of the edge that takes a request.
`timescale 1ns/100ps
module tag_cmd_host (
  input wire logic clk_sys,
  input wire tag_pkg::rsp_t rsp,
  output tag_pkg::cmd_t cmd
);
  import tag_pkg::*;
  initial cmd = '0;
  ////////////////////////////////////////////////////////////////////////
  // One request, then a bounded look for its answer; got stays 0 if none comes
  task automatic xfer(input logic w, input logic [7:0] b, input logic [31:0] d,
      output logic got, output logic ok, output logic [31:0] q);
    got = 1'b0;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk_sys);
    cmd <= '{1'b1, w, b, d};
    @(posedge clk_sys);
    // Released lines never keep a stale copy of the request
    cmd <= '{1'b0, ~w, ~b, ~d};
    repeat (3) begin
      @(negedge clk_sys);
      if (rsp.valid === 1'b1 && !got) begin
        got = 1'b1;
        ok = rsp.ok;
        q = rsp.data;
      end
    end
  endtask
endmodule

// ==== test/tag_startup_and_access_state_test.sv ====
// Bench for the tag start-up and access-state block: bus, boot and commands.
// Assumes the package and the command host model are compiled first.
`timescale 1ns/100ps
module tag_startup_and_access_state_test;
  import tag_pkg::*;
  localparam int NB = 20;
  localparam int RB = 30;
  localparam int WB = 60;
  localparam logic [31:0] KA = 32'h1357_9bdf;
  localparam logic [31:0] KB = 32'h2468_ace0;
  logic clk_sys = 1'b0;
  logic reset_n, pwr_off, sup_ok, carrier, int_wr, hwrite, hreadyout, hresp, irq;
  logic switch_on, standby, core_reset, boot_done, cdet, clk_car;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cmd_t cmd_w, cmd_r;
  rsp_t rsp_w, rsp_r;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  tag_startup_ctrl #(.BOOT_NORMAL_CYCLES(NB), .BOOT_RECOVER_CYCLES(RB),
    .BOOT_WRCOUNT_CYCLES(WB)) tag_startup_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .power_off_request_n(pwr_off), .core_supply_ok(sup_ok), .carrier_present(carrier),
    .interrupted_write(int_wr), .cmd_wired(cmd_w), .cmd_rf(cmd_r), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .rsp_wired(rsp_w), .rsp_rf(rsp_r), .supply_switch_on(switch_on),
    .standby(standby), .core_reset(core_reset), .boot_done(boot_done),
    .carrier_detect_out(cdet), .clock_from_carrier(clk_car), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  tag_cmd_host host_wired (.clk_sys(clk_sys), .rsp(rsp_w), .cmd(cmd_w));
  tag_cmd_host host_rf (.clk_sys(clk_sys), .rsp(rsp_r), .cmd(cmd_r));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic op(input logic rf, input logic w, input logic [7:0] b,
      input logic [31:0] d, input logic eg, input logic eo, input logic [31:0] eq);
    logic g, k;
    logic [31:0] r;
    if (rf) host_rf.xfer(w, b, d, g, k, r);
    else host_wired.xfer(w, b, d, g, k, r);
    chk({30'h0, g, k}, {30'h0, eg, eg & eo});
    if (eg && !w) chk(r, eq);
  endtask
  task automatic auth(input logic rf, input logic [31:0] r);
    op(rf, 1'b1, BLK_CHALLENGE, r, 1'b1, 1'b1, 32'h0);
    op(rf, 1'b0, BLK_DEV_MAC, 32'h0, 1'b1, 1'b1, r ^ KA ^ KB);
    op(rf, 1'b1, BLK_EXT_MAC, r ^ KA ^ {KB[15:0], KB[31:16]}, 1'b1, 1'b1, 32'h0);
  endtask
  task automatic boot_wait(input int lim);
    int n;
    n = 0;
    while (boot_done !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, n <= lim + 4}, 32'h1);
  endtask
  task automatic drop_supply(input int hold);
    sup_ok <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({30'h0, core_reset, boot_done}, 32'h2);
    sup_ok <= 1'b1;
    repeat (hold) @(posedge clk_sys);
  endtask
  // Cut a hang short; counts as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    pwr_off = 1'b0;
    sup_ok = 1'b1;
    carrier = 1'b0;
    int_wr = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (8) @(posedge clk_sys);
    chk({28'h0, core_reset, boot_done, standby, switch_on}, 32'ha);
    reset_n <= 1'b1;
    op(1'b0, 1'b1, 8'h00, 32'h1, 1'b0, 1'b0, 32'h0);
    boot_wait(NB);
    op(1'b0, 1'b1, 8'h05, 32'h1234, 1'b1, 1'b1, 32'h0);
    rd(A_WRCOUNT, 32'h1);
    rd(8'h3c, 32'h0);
    rd(A_MEM_CFG, MEM_CFG_RESET);
    chk({31'h0, irq}, 32'h0);
    wr(A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b0, A_IRQ_STAT, 32'h0, q);
    chk({31'h0, q[0]}, 32'h1);
    ahb(1'b0, A_IRQ_STAT, 32'h0, q);
    chk({31'h0, q[0]}, 32'h0);
    pwr_off <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({29'h0, switch_on, standby, core_reset}, 32'h3);
    pwr_off <= 1'b0;
    boot_wait(NB);
    chk({31'h0, switch_on}, 32'h1);
    int_wr <= 1'b1;
    drop_supply(0);
    boot_wait(RB);
    int_wr <= 1'b0;
    wr(A_MEM_CFG, 32'h0);
    drop_supply(10);
    chk({31'h0, boot_done}, 32'h0);
    drop_supply(0);
    boot_wait(WB);
    rd(A_WRCOUNT, 32'h0);
    wr(A_MEM_CFG, MEM_CFG_RESET);
    carrier <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({30'h0, cdet, clk_car}, 32'h3);
    wr(A_KEY_A, KA);
    wr(A_KEY_B, KB);
    rd(A_KEY_A, 32'h0);
    wr(A_ATTR, 32'h4);
    auth(1'b1, 32'hcafe_0001);
    op(1'b0, 1'b0, 8'h01, 32'h0, 1'b1, 1'b0, 32'h0);
    op(1'b1, 1'b0, BLK_STATE, 32'h0, 1'b1, 1'b1, 32'h1);
    auth(1'b0, 32'h0bad_f00d);
    op(1'b1, 1'b0, BLK_DEV_MAC, 32'h0, 1'b1, 1'b1, 32'hcafe_0001 ^ KA ^ KB);
    op(1'b0, 1'b0, BLK_STATE, 32'h0, 1'b1, 1'b1, 32'h101);
    op(1'b0, 1'b0, 8'h01, 32'h0, 1'b1, 1'b1, 32'h0);
    // Access table: read-only per side, write lock per side, write after auth
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, {31'h0, i == 2 || i == 3});
      wr(A_ATTR, i == 0 ? 32'h1 : i == 1 ? 32'h2 : i == 4 ? 32'h8 : 32'h0);
      wr(A_WRLOCK, i == 2 ? 32'h1 : i == 3 ? 32'h100 : 32'h0);
      op(1'b0, 1'b1, 8'h02, i, 1'b1, 5'b11010 >> i, 32'h0);
      op(1'b1, 1'b1, 8'h02, i, 1'b1, 5'b10101 >> i, 32'h0);
    end
    wr(A_CTRL, 32'h0);
    wr(A_ATTR, 32'h0);
    wr(A_WRLOCK, 32'h101);
    wr(A_POLL, 32'h5a);
    wr(A_ID_LO, 32'h89ab_cdef);
    wr(A_IRQ_MASK, 32'h2);
    ahb(1'b0, A_IRQ_STAT, 32'h0, q);
    carrier <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rd(A_WRLOCK, 32'h100);
    rd(A_POLL, 32'h0);
    rd(A_ID_LO, 32'h0);
    ahb(1'b0, A_STATUS, 32'h0, q);
    chk({30'h0, q[6:5]}, 32'h1);
    op(1'b1, 1'b0, BLK_STATE, 32'h0, 1'b0, 1'b0, 32'h0);
    ahb(1'b0, A_IRQ_STAT, 32'h0, q);
    chk({31'h0, q[1]}, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule
